/* gg_defines.svh */
// Register offsets, reset values and timing counts of the gauge register bank.
// Assumes inclusion by bare name from the design files.
`ifndef GG_DEFINES_SVH
`define GG_DEFINES_SVH

// Register addresses (seven-bit command address field)
`define GG_ADDR_TEMP_FUEL   7'h02
`define GG_ADDR_COUNT_HIGH  7'h03
`define GG_ADDR_PACK_TAG    7'h04
`define GG_ADDR_LEARNED     7'h05
`define GG_ADDR_SEC_FLAGS   7'h06
`define GG_ADDR_PULLDOWN    7'h07
`define GG_ADDR_PULLUP      7'h08
`define GG_ADDR_TALLY       7'h09
`define GG_ADDR_NOISE_BAND  7'h0a
`define GG_ADDR_COUNT_LOW   7'h17
`define GG_ADDR_SOFT_RESET  7'h39

// Command byte write bit and soft reset data byte
`define GG_CMD_WRITE_BIT    7
`define GG_SOFT_RESET_CODE  8'h80

// Secondary flag fields
`define GG_SF_RATE_BIT      7
`define GG_SF_REGIME_LSB    4
`define GG_SF_OVERLOAD_BIT  0
`define GG_REGIME_LIGHT     3'h0
`define GG_REGIME_HEAVY     3'h1

// Reset values and limits
`define GG_NOISE_BAND_RST   8'h00
`define GG_TALLY_MAX        8'hff
`define GG_TALLY_STALE      8'h40
`define GG_SELF_DSG_LIMIT   13'h1000

// Temperature bands and capacity scaling
`define GG_TEMP_LOW_C       (-30)
`define GG_TEMP_HIGH_C      80
`define GG_TEMP_COLD_C      (-20)
`define GG_TEMP_HYST_C      10
`define GG_TEMP_CODE_MAX    4'hc
`define GG_FUEL_MAX         4'hf

// Recharge threshold 0.94 as 47/50
`define GG_FULL_NUM         47
`define GG_FULL_DEN         50

// Sampling resume delay after overload
`define GG_CLK_KHZ          250000
`define GG_RESUME_MS        500

// Efficiency: one count in N is dropped
`define GG_EFF_FAST_N       32
`define GG_EFF_TRICKLE_N    16

`endif

/* gg_pkg.sv */
// Types shared by the gauge register bank.
// Assumes nothing of its surroundings.
package gg_pkg;

  // Serial command engine state, Gray coded along receive, write, send
  typedef enum logic [1:0] {
    GG_RX_CMD  = 2'h0,
    GG_RX_DATA = 2'h1,
    GG_TX_DATA = 2'h3
  } gg_link_state_type;

endpackage

/* gg_sync3.sv */
// Three-stage synchroniser for a pin level.
// Assumes an asynchronous input and one clock.
`timescale 1ns/1ns
module gg_sync3 (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // Level in and out
  input  wire logic i_level,
  output logic      o_level
);

  logic [2:0] stage_r;
  logic       level_r;

  ////////////////////////////////////////////////////////////////////////////
  // Shift chain; the first stage feeds only the second
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stage_r <= 3'h0;
    end else begin
      stage_r <= {stage_r[1:0], i_level};
    end
  end

  // Level changes once stages two and three agree
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      level_r <= 1'b0;
    end else if (stage_r[1] == stage_r[2]) begin
      level_r <= stage_r[2];
    end
  end

  assign o_level = level_r;

endmodule

/* gg_register_bank.sv */
// Register file and bookkeeping of a battery fuel gauge.
// Assumes a bit engine on the same clock that times the single-wire link,
// and sensing units that deliver temperature, comparisons and count events.
`timescale 1ns/1ns
`include "gg_defines.svh"
module gg_register_bank #(
  parameter int RESUME_CYCLES = `GG_RESUME_MS * `GG_CLK_KHZ,
  parameter int EFF_FAST_N    = `GG_EFF_FAST_N,
  parameter int EFF_TRICKLE_N = `GG_EFF_TRICKLE_N
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  // Link bit engine
  input  wire logic              i_rx_bit_valid,
  input  wire logic              i_rx_bit,
  input  wire logic              i_tx_bit_take,
  output logic                   o_tx_valid,
  output logic                   o_tx_bit,
  // Sensing inputs
  input  wire logic signed [7:0] i_temp_c,
  input  wire logic              i_below_150mv,
  input  wire logic              i_below_250mv,
  input  wire logic              i_charge_active,
  input  wire logic              i_rate_fast,
  input  wire logic              i_charge_count,
  input  wire logic              i_discharge_count,
  input  wire logic              i_self_discharge,
  input  wire logic              i_valid_charge,
  input  wire logic              i_first_empty_warning,
  // Program pins
  input  wire logic [7:0]        i_programmed_full_capacity,
  input  wire logic              i_nac_preload_pin,
  input  wire logic [5:0]        i_pin_pulldown_map,
  input  wire logic [5:0]        i_pin_pullup_map,
  // Status to surrounding units
  output logic [7:0]             o_noise_band_setting,
  output logic                   o_charge_rate_flag,
  output logic                   o_sample_enable,
  output logic                   o_stale_capacity_flag,
  output logic                   o_pack_swap_flag,
  output logic                   o_valid_discharge_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  gg_pkg::gg_link_state_type state_r;
  logic [7:0]  rx_sr_r;
  logic [2:0]  bit_cnt_r;
  logic [6:0]  addr_r;
  logic [7:0]  tx_sr_r;
  logic        tx_valid_r;
  logic        wr_pulse;
  logic [7:0]  wr_data;
  logic [7:0]  rx_next;
  logic        init_pend_r;
  logic        soft_rst_r;
  logic        do_init;
  logic        preload;
  logic [15:0] remaining_charge_count_r;
  logic [7:0]  learned_full_capacity_r;
  logic [7:0]  pack_type_tag_r;
  logic [7:0]  noise_band_r;
  logic [7:0]  recharge_tally_r;
  logic        tally_high_done_r;
  logic        tally_inc;
  logic        stale_r;
  logic        swap_r;
  logic        vdq_r;
  logic [15:0] dsg_meas_r;
  logic [12:0] self_dsg_r;
  logic        rate_r;
  logic        charge_active_r;
  logic        overload_r;
  logic        regime_heavy_r;
  logic        sample_en_r;
  logic [31:0] resume_cnt_r;
  logic        cold_r;
  logic [5:0]  eff_cnt_r;
  logic        eff_skip;
  logic        edv_valid;
  logic        learn;
  logic        above_full_thr;
  logic        at_full;
  logic        temp_warm;
  logic [3:0]  temp_code;
  logic [3:0]  fuel_sixteenths;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Band code of a temperature
  function automatic logic [3:0] band_code(input logic signed [7:0] t);
    logic signed [9:0] shifted;
    shifted = 10'(t) + 10'sd40;
    if (t < `GG_TEMP_LOW_C) begin
      band_code = 4'h0;
    end else if (t >= `GG_TEMP_HIGH_C) begin
      band_code = `GG_TEMP_CODE_MAX;
    end else begin
      band_code = 4'(shifted / 10'sd10);
    end
  endfunction

  // Sixteenths of a full reference held by a scaled count (quarters)
  function automatic logic [3:0] sixteenths(input logic [15:0] remaining_charge_count,
                                            input logic [2:0]  quarters,
                                            input logic [7:0]  full);
    logic [23:0] scaled;
    logic [23:0] step;
    logic [3:0]  n;
    scaled = 24'(remaining_charge_count) * 24'(quarters) * 24'd4;
    step   = {8'h00, full, 8'h00};
    n      = 4'h0;
    for (int k = 1; k <= 15; k++) begin
      if (scaled >= step * 24'(k)) begin
        n = 4'(k);
      end
    end
    sixteenths = n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Preload pin passes a three-stage synchroniser
  gg_sync3 u_preload_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_level   (i_nac_preload_pin),
    .o_level   (preload)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link command engine: bytes arrive and leave LSB first
  assign rx_next = {i_rx_bit, rx_sr_r[7:1]};
  assign wr_pulse = (state_r == gg_pkg::GG_RX_DATA) && i_rx_bit_valid &&
                    (bit_cnt_r == 3'h7);
  assign wr_data  = rx_next;

  // Register read decode; unmapped addresses read zero
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    unique case (a)
      `GG_ADDR_TEMP_FUEL:  reg_read = {temp_code, fuel_sixteenths};
      `GG_ADDR_COUNT_HIGH: reg_read = remaining_charge_count_r[15:8];
      `GG_ADDR_COUNT_LOW:  reg_read = remaining_charge_count_r[7:0];
      `GG_ADDR_PACK_TAG:   reg_read = pack_type_tag_r;
      `GG_ADDR_LEARNED:    reg_read = learned_full_capacity_r;
      `GG_ADDR_SEC_FLAGS:  reg_read = {rate_r,
                                       regime_heavy_r ? `GG_REGIME_HEAVY
                                                      : `GG_REGIME_LIGHT,
                                       3'h0, overload_r};
      `GG_ADDR_PULLDOWN:   reg_read = {2'h0, i_pin_pulldown_map};
      `GG_ADDR_PULLUP:     reg_read = {2'h0, i_pin_pullup_map};
      `GG_ADDR_TALLY:      reg_read = recharge_tally_r;
      `GG_ADDR_NOISE_BAND: reg_read = noise_band_r;
      default:             reg_read = 8'h00;
    endcase
  endfunction

  // Receive, decode and send state machine
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r    <= gg_pkg::GG_RX_CMD;
      rx_sr_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      addr_r     <= 7'h00;
      tx_sr_r    <= 8'h00;
      tx_valid_r <= 1'b0;
    end else begin
      unique case (state_r)
        gg_pkg::GG_RX_CMD, gg_pkg::GG_RX_DATA: begin
          if (i_rx_bit_valid) begin
            rx_sr_r   <= rx_next;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7 && state_r == gg_pkg::GG_RX_DATA) begin
              state_r <= gg_pkg::GG_RX_CMD;
            end else if (bit_cnt_r == 3'h7) begin
              addr_r <= rx_next[6:0];
              if (rx_next[`GG_CMD_WRITE_BIT]) begin
                state_r <= gg_pkg::GG_RX_DATA;
              end else begin
                tx_sr_r    <= reg_read(rx_next[6:0]);
                tx_valid_r <= 1'b1;
                state_r    <= gg_pkg::GG_TX_DATA;
              end
            end
          end
        end
        gg_pkg::GG_TX_DATA: begin
          if (i_tx_bit_take) begin
            tx_sr_r   <= {1'b0, tx_sr_r[7:1]};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              tx_valid_r <= 1'b0;
              state_r    <= gg_pkg::GG_RX_CMD;
            end
          end
        end
        default: begin
          state_r <= gg_pkg::GG_RX_CMD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device reset: once after release, and on a soft reset write
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      init_pend_r <= 1'b1;
      soft_rst_r  <= 1'b0;
    end else begin
      init_pend_r <= 1'b0;
      soft_rst_r  <= wr_pulse && addr_r == `GG_ADDR_SOFT_RESET &&
                     wr_data == `GG_SOFT_RESET_CODE;
    end
  end
  assign do_init = init_pend_r | soft_rst_r;

  ////////////////////////////////////////////////////////////////////////////
  // Temperature band, cold scaling with hysteresis, capacity readout
  assign temp_code = band_code(i_temp_c);
  assign temp_warm = (i_temp_c >= 8'sd0);

  // Cold below 0 degC, warm again only from 10 degC
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cold_r <= 1'b0;
    end else if (i_temp_c < 8'sd0) begin
      cold_r <= 1'b1;
    end else if (i_temp_c >= `GG_TEMP_HYST_C) begin
      cold_r <= 1'b0;
    end
  end

  assign fuel_sixteenths = sixteenths(remaining_charge_count_r,
                             !cold_r ? 3'h4 :
                             (i_temp_c < `GG_TEMP_COLD_C) ? 3'h2 : 3'h3,
                             learned_full_capacity_r);

  ////////////////////////////////////////////////////////////////////////////
  // Secondary flags: charge rate, discharge regime, overload
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      charge_active_r <= 1'b0;
      rate_r          <= 1'b0;
      overload_r      <= 1'b0;
      regime_heavy_r  <= 1'b0;
    end else begin
      charge_active_r <= i_charge_active;
      overload_r      <= i_below_250mv;
      regime_heavy_r  <= i_below_150mv;
      if (i_charge_active && !charge_active_r) begin
        rate_r <= 1'b1;
      end else if (!i_rate_fast) begin
        rate_r <= 1'b0;
      end
    end
  end

  // End-of-discharge sampling halts in overload, resumes after the delay
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sample_en_r  <= 1'b1;
      resume_cnt_r <= 32'h0000_0000;
    end else if (overload_r) begin
      sample_en_r  <= 1'b0;
      resume_cnt_r <= 32'h0000_0000;
    end else if (!sample_en_r) begin
      if (resume_cnt_r == 32'(RESUME_CYCLES - 1)) begin
        sample_en_r <= 1'b1;
      end else begin
        resume_cnt_r <= resume_cnt_r + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge efficiency: drop one count in N, N set by the rate regime
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      eff_cnt_r <= 6'h00;
    end else if (i_charge_count) begin
      eff_cnt_r <= eff_skip ? 6'h00 : eff_cnt_r + 6'h01;
    end
  end
  assign eff_skip = (eff_cnt_r == 6'(rate_r ? EFF_FAST_N - 1 : EFF_TRICKLE_N - 1));

  assign edv_valid = i_first_empty_warning & sample_en_r;
  assign at_full   = remaining_charge_count_r[15:8] >= learned_full_capacity_r;
  assign above_full_thr = 24'(remaining_charge_count_r) * 24'(`GG_FULL_DEN) >=
                          24'({learned_full_capacity_r, 8'h00}) * 24'(`GG_FULL_NUM);
  assign learn = edv_valid && vdq_r && temp_warm &&
                 self_dsg_r < `GG_SELF_DSG_LIMIT;

  ////////////////////////////////////////////////////////////////////////////
  // Remaining charge counter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      remaining_charge_count_r <= 16'h0000;
    end else if (do_init) begin
      remaining_charge_count_r <= preload ? {i_programmed_full_capacity, 8'h00}
                                          : 16'h0000;
    end else if (edv_valid) begin
      remaining_charge_count_r <= 16'h0000;
    end else if (wr_pulse && addr_r == `GG_ADDR_COUNT_HIGH) begin
      remaining_charge_count_r[15:8] <= wr_data;
    end else if (i_charge_count && !eff_skip &&
                 remaining_charge_count_r != 16'hffff) begin
      remaining_charge_count_r <= remaining_charge_count_r + 16'h0001;
    end else if ((i_discharge_count || i_self_discharge) &&
                 remaining_charge_count_r != 16'h0000) begin
      remaining_charge_count_r <= remaining_charge_count_r - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host storage registers
  always_ff @(posedge i_ref_clk) begin
    if (wr_pulse && addr_r == `GG_ADDR_PACK_TAG) begin
      pack_type_tag_r <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      noise_band_r <= `GG_NOISE_BAND_RST;
    end else if (wr_pulse && addr_r == `GG_ADDR_NOISE_BAND) begin
      noise_band_r <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Learned capacity, discharge measurement and self-discharge count
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      learned_full_capacity_r <= 8'h00;
    end else if (do_init) begin
      learned_full_capacity_r <= i_programmed_full_capacity;
    end else if (learn) begin
      learned_full_capacity_r <= dsg_meas_r[15:8];
    end else if (wr_pulse && addr_r == `GG_ADDR_LEARNED) begin
      learned_full_capacity_r <= wr_data;
    end
  end

  // Valid discharge starts with the first discharge count from full
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      vdq_r      <= 1'b0;
      dsg_meas_r <= 16'h0000;
      self_dsg_r <= 13'h0000;
    end else if (do_init || edv_valid || i_valid_charge ||
                 self_dsg_r >= `GG_SELF_DSG_LIMIT) begin
      vdq_r <= 1'b0;
    end else if (i_discharge_count && at_full) begin
      vdq_r      <= 1'b1;
      dsg_meas_r <= 16'h0001;
      self_dsg_r <= 13'h0000;
    end else if (vdq_r) begin
      if (i_discharge_count || i_self_discharge) begin
        dsg_meas_r <= dsg_meas_r + 16'h0001;
      end
      if (i_self_discharge) begin
        self_dsg_r <= self_dsg_r + 13'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recharge tally and stale capacity flag
  // A valid charge that the tally really counts; stale follows the same count
  assign tally_inc = i_valid_charge && !(above_full_thr && tally_high_done_r) &&
                     recharge_tally_r != `GG_TALLY_MAX;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      recharge_tally_r  <= 8'h00;
      tally_high_done_r <= 1'b0;
    end else if (do_init || learn) begin
      recharge_tally_r  <= 8'h00;
      tally_high_done_r <= 1'b0;
    end else begin
      if (!above_full_thr) begin
        tally_high_done_r <= 1'b0;
      end else if (i_valid_charge) begin
        tally_high_done_r <= 1'b1;
      end
      if (tally_inc) begin
        recharge_tally_r <= recharge_tally_r + 8'h01;
      end
    end
  end

  // Stale flag: set at reset and at tally 64, cleared by learning
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stale_r <= 1'b1;
    end else if (do_init) begin
      stale_r <= 1'b1;
    end else if (tally_inc && recharge_tally_r == `GG_TALLY_STALE - 8'h01) begin
      stale_r <= 1'b1;
    end else if (learn) begin
      stale_r <= 1'b0;
    end
  end

  // Pack swap flag: set by reset, cleared by a valid charge while at full
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      swap_r <= 1'b1;
    end else if (do_init) begin
      swap_r <= 1'b1;
    end else if (i_valid_charge && at_full) begin
      swap_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign o_tx_valid             = tx_valid_r;
  assign o_tx_bit               = tx_sr_r[0];
  assign o_noise_band_setting   = noise_band_r;
  assign o_charge_rate_flag     = rate_r;
  assign o_sample_enable        = sample_en_r;
  assign o_stale_capacity_flag  = stale_r;
  assign o_pack_swap_flag       = swap_r;
  assign o_valid_discharge_flag = vdq_r;

endmodule

/* gg_chk.sv */
// Port checker of the gauge register bank.
// Assumes a bind onto gg_register_bank in one clock domain.
`timescale 1ns/1ns
module gg_chk (
  // Clock, reset and inputs
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_rx_bit_valid,
  input wire logic       i_tx_bit_take,
  input wire logic       i_below_250mv,
  input wire logic       i_charge_active,
  input wire logic       i_rate_fast,
  // Outputs watched
  input wire logic       o_tx_valid,
  input wire logic       o_tx_bit,
  input wire logic [7:0] o_noise_band_setting,
  input wire logic       o_charge_rate_flag,
  input wire logic       o_sample_enable,
  input wire logic       o_stale_capacity_flag,
  input wire logic       o_pack_swap_flag,
  input wire logic       o_valid_discharge_flag
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Link, overload, rate and init relations
  property p_hold; o_tx_valid && !i_tx_bit_take |=> $stable(o_tx_bit) || !o_tx_valid; endproperty
  a_hold: assert property (p_hold) else $error("tx bit moved without take");
  property p_end; $fell(o_tx_valid) |-> $past(i_tx_bit_take) || $past(i_tx_bit_take, 2); endproperty
  a_end: assert property (p_end) else $error("send ended without take");
  property p_overload_flag; i_below_250mv [*3] |-> !o_sample_enable; endproperty
  a_overload_flag: assert property (p_overload_flag) else $error("sampling on in overload");
  property p_rsm; $fell(i_below_250mv) && $past(i_below_250mv, 2) |-> ##1 !o_sample_enable; endproperty
  a_rsm: assert property (p_rsm) else $error("sampling resumed early");
  property p_rset; $rose(i_charge_active) |=> o_charge_rate_flag; endproperty
  a_rset: assert property (p_rset) else $error("rate flag not set");
  property p_rclr; !i_charge_active && !i_rate_fast |=> !o_charge_rate_flag; endproperty
  a_rclr: assert property (p_rclr) else $error("rate flag stuck");
  property p_init;
    $fell(i_rst) |-> o_stale_capacity_flag && o_pack_swap_flag && !o_valid_discharge_flag;
  endproperty
  a_init: assert property (p_init) else $error("reset flags wrong");
  property p_nb; $changed(o_noise_band_setting) |-> $past(i_rx_bit_valid)
    || $past(i_rx_bit_valid, 2) || $past(i_rx_bit_valid, 3); endproperty
  a_nb: assert property (p_nb) else $error("noise band changed alone");
  c_read: cover property ($rose(o_tx_valid));
  c_overload_flag: cover property ($fell(o_sample_enable));
  c_rate: cover property ($rose(o_charge_rate_flag));
endmodule

/* gg_host.sv */
// Host model driving the link bit engine side of the register bank.
// Assumes the bank clock; bits change 1 ns after a rising edge.
`timescale 1ns/1ns
module gg_host (
  // Clock and answer
  input  wire logic i_ref_clk,
  input  wire logic o_tx_valid,
  input  wire logic o_tx_bit,
  // Bit engine strobes
  output logic      i_rx_bit_valid,
  output logic      i_rx_bit,
  output logic      i_tx_bit_take
);
  initial begin
    i_rx_bit_valid = 1'b0;
    i_rx_bit = 1'b0;
    i_tx_bit_take = 1'b0;
  end
  // Byte out least significant bit first; idle line shows inverse
  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_ref_clk);
      #1;
      i_rx_bit_valid = 1'b1;
      i_rx_bit = b[i];
    end
    @(posedge i_ref_clk);
    #1;
    i_rx_bit_valid = 1'b0;
    i_rx_bit = ~i_rx_bit;
  endtask
  // Command bit 7 selects write, then data
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    put({1'b1, a});
    put(v);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    put({1'b0, a});
    for (int k = 0; k < 20 && !o_tx_valid; k++) begin
      @(posedge i_ref_clk);
      #1;
    end
    // Leave the first bit standing one cycle untaken
    @(posedge i_ref_clk);
    #1;
    for (int i = 0; i < 8; i++) begin
      v[i] = o_tx_bit;
      i_tx_bit_take = 1'b1;
      @(posedge i_ref_clk);
      #1;
    end
    i_tx_bit_take = 1'b0;
  endtask
endmodule

/* tb.sv */
// Self-checking bench of the gauge register bank.
// Assumes gg_host as link partner and gg_chk bound to the bank.
`timescale 1ns/1ns
module tb;
  logic              i_ref_clk = 0, i_rst = 1, i_rx_bit_valid, i_rx_bit, i_tx_bit_take;
  logic              i_below_150mv = 0, i_below_250mv = 0, i_charge_active = 0;
  logic              i_valid_charge = 0, i_first_empty_warning = 0;
  logic              i_rate_fast = 0, i_charge_count = 0, i_discharge_count = 0;
  logic              i_nac_preload_pin = 0;
  logic signed [7:0] i_temp_c = 8'sh19;
  logic [5:0]        i_pin_pulldown_map = 6'h00, i_pin_pullup_map = 6'h00;
  logic              o_tx_valid, o_tx_bit, o_charge_rate_flag, o_sample_enable;
  logic              o_stale_capacity_flag, o_pack_swap_flag, o_valid_discharge_flag;
  logic [7:0]        o_noise_band_setting, d, programmed_full_capacity = 8'h80;
  logic signed [7:0] tt [5] = '{8'sh19, -8'sh19, 8'sh05, 8'sh55, -8'sh23};
  logic [7:0]        te [5] = '{8'h68, 8'h14, 8'h46, 8'hc8, 8'h04};
  int                error_cnt = 0, checked = 0;
  always #2 i_ref_clk = ~i_ref_clk;
  gg_host u_host (.i_ref_clk, .o_tx_valid, .o_tx_bit, .i_rx_bit_valid, .i_rx_bit, .i_tx_bit_take);
  gg_register_bank #(.RESUME_CYCLES(20)) u_dut (.i_ref_clk, .i_rst, .i_rx_bit_valid, .i_rx_bit,
    .i_tx_bit_take, .o_tx_valid, .o_tx_bit, .i_temp_c, .i_below_150mv, .i_below_250mv,
    .i_charge_active, .i_rate_fast, .i_charge_count, .i_discharge_count,
    .i_self_discharge(1'b0), .i_valid_charge, .i_first_empty_warning,
    .i_programmed_full_capacity(programmed_full_capacity), .i_nac_preload_pin, .i_pin_pulldown_map,
    .i_pin_pullup_map, .o_noise_band_setting, .o_charge_rate_flag, .o_sample_enable,
    .o_stale_capacity_flag, .o_pack_swap_flag, .o_valid_discharge_flag);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    cmp(d, e);
  endtask
  task automatic pulse_vc(input int n);
    repeat (n) begin
      i_valid_charge = 1'b1;
      tick(1);
      i_valid_charge = 1'b0;
      tick(1);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_init_regs;
    rdc(7'h05, programmed_full_capacity);
    rdc(7'h03, 8'h00);
    rdc(7'h17, 8'h00);
    cmp({5'h00, o_stale_capacity_flag, o_pack_swap_flag, o_valid_discharge_flag}, 8'h06);
    u_host.wr(7'h04, 8'ha5);
    rdc(7'h04, 8'ha5);
    u_host.wr(7'h0a, 8'h3c);
    rdc(7'h0a, 8'h3c);
    cmp(o_noise_band_setting, 8'h3c);
    u_host.wr(7'h09, 8'h55);
    rdc(7'h09, 8'h00);
    rdc(7'h01, 8'h00);
    $display("test init_regs done");
  endtask
  task automatic t_gauge;
    u_host.wr(7'h03, 8'h40);
    for (int i = 0; i < 5; i++) begin
      i_temp_c = tt[i];
      tick(4);
      rdc(7'h02, te[i]);
    end
    rdc(7'h17, 8'h00);
    i_pin_pulldown_map = 6'h09;
    i_pin_pullup_map = 6'h24;
    i_below_150mv = 1'b1;
    i_below_250mv = 1'b1;
    tick(4);
    rdc(7'h07, 8'h09);
    rdc(7'h08, 8'h24);
    rdc(7'h06, 8'h11);
    i_below_150mv = 1'b0;
    i_below_250mv = 1'b0;
    tick(30);
    rdc(7'h06, 8'h00);
    cmp({7'h00, o_sample_enable}, 8'h01);
    i_first_empty_warning = 1'b1;
    tick(1);
    i_first_empty_warning = 1'b0;
    tick(2);
    rdc(7'h03, 8'h00);
    i_charge_count = 1'b1;
    tick(3);
    i_charge_count = 1'b0;
    i_discharge_count = 1'b1;
    tick(1);
    i_discharge_count = 1'b0;
    tick(2);
    rdc(7'h17, 8'h02);
    $display("test gauge done");
  endtask
  task automatic t_tally_reset;
    i_charge_active = 1'b1;
    i_rate_fast = 1'b1;
    tick(3);
    cmp({7'h00, o_charge_rate_flag}, 8'h01);
    i_rate_fast = 1'b0;
    tick(2);
    cmp({7'h00, o_charge_rate_flag}, 8'h00);
    i_charge_active = 1'b0;
    pulse_vc(3);
    rdc(7'h09, 8'h03);
    pulse_vc(300);
    rdc(7'h09, 8'hff);
    u_host.wr(7'h05, 8'h20);
    rdc(7'h05, 8'h20);
    i_nac_preload_pin = 1'b1;
    u_host.wr(7'h39, 8'h80);
    tick(4);
    rdc(7'h05, programmed_full_capacity);
    rdc(7'h03, programmed_full_capacity);
    rdc(7'h17, 8'h00);
    rdc(7'h09, 8'h00);
    $display("test tally_reset done");
  endtask
  initial begin
    tick(6);
    i_rst = 1'b0;
    tick(2);
    t_init_regs();
    t_gauge();
    t_tally_reset();
    stop_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule
bind gg_register_bank gg_chk u_chk (.i_ref_clk, .i_rst, .i_rx_bit_valid, .i_tx_bit_take,
  .i_below_250mv, .i_charge_active, .i_rate_fast, .o_tx_valid, .o_tx_bit,
  .o_noise_band_setting, .o_charge_rate_flag, .o_sample_enable, .o_stale_capacity_flag,
  .o_pack_swap_flag, .o_valid_discharge_flag);
